/* File: hdl/avf_top.v */
// command interpreter for analog setup, amplifier volume, fade and flash entry
// assumes bytes arrive one per cycle-pulse, first byte of a command flagged
// What this block does
// - speaker mode: enables 00 powers down, 01 powers up; pop bit ignored.
// - line out on speaker-positive pin: enables 10 up, 00 down, pop chooses.
// - line out on line pin: enables 11 up, 00 down, pop chooses.
// - line output ramps ground to mid-reference using suppressed or plain durations.
// - analog off: negative speaker floats, positive grounded, reference and line grounded.
// - amp volume is two bytes, 4-bit code in bits 5..2, rest zero.
// - amp volume accepted regardless of channel ready flags.
// - volume resets to code 8; 0 mutes; codes 1 and 2 prohibited.
// - volume survives playback stop, returns to code 8 on power-down.
// - fade is two bytes: step in bits 3..1, enable bit 0; starts off.
// - fade accepted regardless of ready flags; ramps channel volume changes.
// - each group period moves 128/32768 shifted right by the step field.
// - ramp lasts code difference times period times rounded-up 264 ratio.
// - flash mode entered only if stored code not 0x69 and codes match.
// - stored code 0x69 never allows flash mode.
// - flash mode ends only by reset; no command leaves it.
// - flash-direct arriving over the I2C port is ignored.
// - analog setup ignored when powered down, transitioning, or playing.
// - analog setup returns to initial values on reset or power-down.
`timescale 1ns/1ns
`default_nettype none
`include "avf_defs.vh"

module avf_top #(
  parameter CHANNELS = 4,
  parameter VOL_W = 7,
  parameter SUP_RISE_NS = `AVF_SUP_RISE_NS,
  parameter SUP_FALL_NS = `AVF_SUP_FALL_NS,
  parameter PLAIN_RISE_NS = `AVF_PLAIN_RISE_NS,
  parameter PLAIN_FALL_NS = `AVF_PLAIN_FALL_NS
) (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // command bytes
  input wire [7:0] cmd_byte,
  input wire cmd_valid,
  input wire cmd_first,
  input wire cmd_from_i2c,
  // chip state
  input wire chip_powered,
  input wire chip_transition,
  input wire playing,
  input wire power_down_evt,
  input wire [7:0] stored_protect_code,
  // channel volume changes
  input wire group_tick,
  input wire [CHANNELS-1:0] chan_vol_wr,
  input wire [CHANNELS*VOL_W-1:0] chan_vol_code,
  // analog settings
  output reg amp_class_sel_r,
  output reg hpf_en_r,
  output reg stop_fade_r,
  output reg [1:0] dac_gain_r,
  output reg [1:0] ain_gain_r,
  output reg analog_enable_hi_r,
  output reg analog_enable_lo_r,
  output reg pop_suppress_r,
  // analog state and pins
  output reg analog_up_r,
  output reg analog_busy_r,
  output reg line_at_mid_r,
  output reg speaker_neg_out_oe_r,
  output reg speaker_pos_out_gnd_r,
  output reg mid_reference_out_gnd_r,
  output reg line_out_pin_gnd_r,
  // volume and fade
  output reg [3:0] amp_volume_code_r,
  output reg fade_en_r,
  output reg [2:0] ramp_step_sel_r,
  output wire [CHANNELS*16-1:0] chan_gain,
  output wire [CHANNELS-1:0] chan_ramp_busy,
  // flash access
  output reg flash_access_r
);

  // transition durations in cycles, rounded up, at least one
  localparam integer SUP_RISE_CYC = (SUP_RISE_NS + `AVF_CLK_PERIOD_NS - 1) / `AVF_CLK_PERIOD_NS;
  localparam integer SUP_FALL_CYC = (SUP_FALL_NS + `AVF_CLK_PERIOD_NS - 1) / `AVF_CLK_PERIOD_NS;
  localparam integer PLAIN_RISE_CYC = (PLAIN_RISE_NS + `AVF_CLK_PERIOD_NS - 1) / `AVF_CLK_PERIOD_NS;
  localparam integer PLAIN_FALL_CYC = (PLAIN_FALL_NS + `AVF_CLK_PERIOD_NS - 1) / `AVF_CLK_PERIOD_NS;
  localparam [23:0] SUP_RISE_C = (SUP_RISE_CYC < 1) ? 24'h000001 : SUP_RISE_CYC[23:0];
  localparam [23:0] SUP_FALL_C = (SUP_FALL_CYC < 1) ? 24'h000001 : SUP_FALL_CYC[23:0];
  localparam [23:0] PLAIN_RISE_C = (PLAIN_RISE_CYC < 1) ? 24'h000001 : PLAIN_RISE_CYC[23:0];
  localparam [23:0] PLAIN_FALL_C = (PLAIN_FALL_CYC < 1) ? 24'h000001 : PLAIN_FALL_CYC[23:0];

  // analog states
  localparam [1:0] ST_OFF = 2'b00;
  localparam [1:0] ST_RISE = 2'b01;
  localparam [1:0] ST_ON = 2'b10;
  localparam [1:0] ST_FALL = 2'b11;

  // command collector
  reg pend_r;
  reg [7:0] op_r;
  reg pend_nxt;
  reg [7:0] op_nxt;
  wire is_analog_setup_cmd_w = (op_r[7:2] == `AVF_OPC_ANALOG_SETUP_CMD_TOP);
  wire is_amp_volume_cmd_w = (op_r == `AVF_OPC_AMP_VOLUME_CMD);
  wire is_fade_w = (op_r == `AVF_OPC_FADE);
  wire is_fdir_w = (op_r == `AVF_OPC_FLASH_DIRECT_CMD);
  wire known_w = (cmd_byte[7:2] == `AVF_OPC_ANALOG_SETUP_CMD_TOP) || (cmd_byte == `AVF_OPC_AMP_VOLUME_CMD) ||
                 (cmd_byte == `AVF_OPC_FADE) || (cmd_byte == `AVF_OPC_FLASH_DIRECT_CMD);
  wire second_w = cmd_valid && !cmd_first && pend_r;

  always @* begin
    pend_nxt = pend_r;
    op_nxt = op_r;
    if (cmd_valid && cmd_first) begin
      pend_nxt = known_w;
      op_nxt = cmd_byte;
    end else if (second_w) begin
      pend_nxt = 1'b0;
    end
    if (power_down_evt) begin
      pend_nxt = 1'b0;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_r <= 1'b0;
      op_r <= 8'h00;
    end else begin
      pend_r <= pend_nxt;
      op_r <= op_nxt;
    end
  end

  // full command decodes, applied on the second byte
  wire [3:0] vol_field_w = cmd_byte[`AVF_VOL_MSB:`AVF_VOL_LSB];
  wire amp_volume_cmd_ok_w = (cmd_byte[7:6] == 2'b00) && (cmd_byte[1:0] == 2'b00) &&
                   (vol_field_w != `AVF_VOL_BAD1) && (vol_field_w != `AVF_VOL_BAD2);
  wire amp_volume_cmd_go_w = second_w && is_amp_volume_cmd_w && amp_volume_cmd_ok_w;
  wire fade_go_w = second_w && is_fade_w && (cmd_byte[7:4] == 4'h0);
  wire fdir_go_w = second_w && is_fdir_w && !cmd_from_i2c && chip_powered;
  reg [1:0] ast_r;
  wire analog_setup_cmd_go_w = second_w && is_analog_setup_cmd_w && chip_powered && !chip_transition && !playing &&
                    (ast_r == ST_OFF || ast_r == ST_ON);

  wire new_hi_w = cmd_byte[`AVF_B2_EN_HI];
  wire new_lo_w = cmd_byte[`AVF_B2_EN_LO];
  wire new_pop_w = cmd_byte[`AVF_B2_POP];
  wire want_up_w = new_hi_w | new_lo_w;
  wire spk_mode_w = !new_hi_w && new_lo_w;

  // analog setup registers
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      amp_class_sel_r <= 1'b0;
      hpf_en_r <= 1'b0;
      stop_fade_r <= 1'b0;
      dac_gain_r <= 2'b00;
      ain_gain_r <= 2'b00;
      analog_enable_hi_r <= 1'b0;
      analog_enable_lo_r <= 1'b0;
      pop_suppress_r <= 1'b0;
    end else if (power_down_evt) begin
      amp_class_sel_r <= 1'b0;
      hpf_en_r <= 1'b0;
      stop_fade_r <= 1'b0;
      dac_gain_r <= 2'b00;
      ain_gain_r <= 2'b00;
      analog_enable_hi_r <= 1'b0;
      analog_enable_lo_r <= 1'b0;
      pop_suppress_r <= 1'b0;
    end else if (analog_setup_cmd_go_w) begin
      amp_class_sel_r <= op_r[`AVF_B1_AMP_CLASS_SEL];
      hpf_en_r <= op_r[`AVF_B1_HPF];
      stop_fade_r <= cmd_byte[`AVF_B2_FAD];
      dac_gain_r <= cmd_byte[`AVF_B2_DAG_MSB:`AVF_B2_DAG_LSB];
      ain_gain_r <= cmd_byte[`AVF_B2_AIG_MSB:`AVF_B2_AIG_LSB];
      analog_enable_hi_r <= new_hi_w;
      analog_enable_lo_r <= new_lo_w;
      pop_suppress_r <= new_pop_w;
    end
  end

  // analog power sequencer
  reg [23:0] tmr_r;
  reg [1:0] ast_nxt;
  reg [23:0] tmr_nxt;

  always @* begin
    ast_nxt = ast_r;
    tmr_nxt = tmr_r;
    case (ast_r)
      ST_OFF: begin
        if (analog_setup_cmd_go_w && want_up_w) begin
          ast_nxt = ST_RISE;
          tmr_nxt = (new_pop_w && !spk_mode_w) ? SUP_RISE_C : PLAIN_RISE_C;
        end
      end
      ST_RISE: begin
        if (tmr_r <= 24'h000001) begin
          ast_nxt = ST_ON;
          tmr_nxt = 24'h000000;
        end else begin
          tmr_nxt = tmr_r - 24'h000001;
        end
      end
      ST_ON: begin
        if (analog_setup_cmd_go_w && !want_up_w) begin
          ast_nxt = ST_FALL;
          tmr_nxt = (new_pop_w && analog_enable_hi_r) ? SUP_FALL_C : PLAIN_FALL_C;
        end
      end
      ST_FALL: begin
        if (tmr_r <= 24'h000001) begin
          ast_nxt = ST_OFF;
          tmr_nxt = 24'h000000;
        end else begin
          tmr_nxt = tmr_r - 24'h000001;
        end
      end
      default: begin
        ast_nxt = ST_OFF;
        tmr_nxt = 24'h000000;
      end
    endcase
    if (power_down_evt) begin
      ast_nxt = ST_OFF;
      tmr_nxt = 24'h000000;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ast_r <= ST_OFF;
      tmr_r <= 24'h000000;
      analog_up_r <= 1'b0;
      analog_busy_r <= 1'b0;
      line_at_mid_r <= 1'b0;
      speaker_neg_out_oe_r <= 1'b0;
      speaker_pos_out_gnd_r <= 1'b1;
      mid_reference_out_gnd_r <= 1'b1;
      line_out_pin_gnd_r <= 1'b1;
    end else begin
      ast_r <= ast_nxt;
      tmr_r <= tmr_nxt;
      analog_up_r <= (ast_nxt == ST_ON);
      analog_busy_r <= (ast_nxt == ST_RISE) || (ast_nxt == ST_FALL);
      line_at_mid_r <= (ast_nxt == ST_ON) && analog_enable_hi_r;
      speaker_neg_out_oe_r <= (ast_nxt != ST_OFF);
      speaker_pos_out_gnd_r <= (ast_nxt == ST_OFF);
      mid_reference_out_gnd_r <= (ast_nxt == ST_OFF);
      line_out_pin_gnd_r <= (ast_nxt == ST_OFF);
    end
  end

  // amplifier volume and fade settings
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      amp_volume_code_r <= `AVF_VOL_RESET;
      fade_en_r <= 1'b0;
      ramp_step_sel_r <= `AVF_FADE_SEL_RESET;
    end else if (power_down_evt) begin
      amp_volume_code_r <= `AVF_VOL_RESET;
      fade_en_r <= 1'b0;
      ramp_step_sel_r <= `AVF_FADE_SEL_RESET;
    end else begin
      if (amp_volume_cmd_go_w) begin
        amp_volume_code_r <= vol_field_w;
      end
      if (fade_go_w) begin
        fade_en_r <= cmd_byte[`AVF_FADE_EN_BIT];
        ramp_step_sel_r <= cmd_byte[`AVF_FADE_SEL_MSB:`AVF_FADE_SEL_LSB];
      end
    end
  end

  // flash access entry, left only by reset
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flash_access_r <= 1'b0;
    end else if (fdir_go_w && (stored_protect_code != `AVF_PROTECT_LOCK) &&
                 (cmd_byte == stored_protect_code)) begin
      flash_access_r <= 1'b1;
    end
  end

  // per-channel volume ramps
  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi = gi + 1) begin : g_ch
      avf_ramp #(
        .VOL_W(VOL_W)
      ) u_ramp (
        .clk(clk),
        .sys_rst(sys_rst),
        .vol_wr(chan_vol_wr[gi]),
        .vol_code(chan_vol_code[gi*VOL_W +: VOL_W]),
        .fade_en(fade_en_r),
        .step_sel(ramp_step_sel_r),
        .group_tick(group_tick),
        .clear(power_down_evt),
        .gain_r(chan_gain[gi*16 +: 16]),
        .ramp_busy_r(chan_ramp_busy[gi]),
        .ramp_left_r()
      );
    end
  endgenerate

endmodule
`default_nettype wire

/* File: shared/avf_defs.vh */
// constants for the analog setup, volume, fade and flash-entry command block
// assumes one clock at 250 MHz and byte-wide command delivery
`ifndef AVF_DEFS_VH
`define AVF_DEFS_VH

`define AVF_CLK_PERIOD_NS 4

// first-byte opcodes
`define AVF_OPC_ANALOG_SETUP_CMD_TOP 6'h01
`define AVF_OPC_AMP_VOLUME_CMD 8'h08
`define AVF_OPC_FADE 8'h0C
`define AVF_OPC_FLASH_DIRECT_CMD 8'h10

// analog setup fields, first byte
`define AVF_B1_AMP_CLASS_SEL 1
`define AVF_B1_HPF 0
// analog setup fields, second byte
`define AVF_B2_FAD 7
`define AVF_B2_DAG_MSB 6
`define AVF_B2_DAG_LSB 5
`define AVF_B2_AIG_MSB 4
`define AVF_B2_AIG_LSB 3
`define AVF_B2_EN_HI 2
`define AVF_B2_EN_LO 1
`define AVF_B2_POP 0

// amplifier volume field and codes
`define AVF_VOL_MSB 5
`define AVF_VOL_LSB 2
`define AVF_VOL_RESET 4'h8
`define AVF_VOL_BAD1 4'h1
`define AVF_VOL_BAD2 4'h2

// fade fields
`define AVF_FADE_SEL_MSB 3
`define AVF_FADE_SEL_LSB 1
`define AVF_FADE_EN_BIT 0
`define AVF_FADE_SEL_RESET 3'h0

// ramp arithmetic
`define AVF_STEP_FULL 16'h0080
`define AVF_PERIOD_NUM 18'h00108
`define AVF_PERIOD_RND 18'h000FF
`define AVF_PERIOD_SHIFT 8
`define AVF_GAIN_SHIFT 8

// flash protection
`define AVF_PROTECT_LOCK 8'h69

// line output transition times in ns
`define AVF_SUP_RISE_NS 100000
`define AVF_SUP_FALL_NS 100000
`define AVF_PLAIN_RISE_NS 20000
`define AVF_PLAIN_FALL_NS 20000

`endif

/* File: hdl/avf_ramp.v */
// one channel volume ramp: steps the gain toward a new code each group period
// assumes group_tick is a one-cycle pulse once per sampling-group period
`timescale 1ns/1ns
`default_nettype none
`include "avf_defs.vh"

module avf_ramp #(
  parameter VOL_W = 7
) (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // control
  input wire vol_wr,
  input wire [VOL_W-1:0] vol_code,
  input wire fade_en,
  input wire [2:0] step_sel,
  input wire group_tick,
  input wire clear,
  // state
  output reg [15:0] gain_r,
  output reg ramp_busy_r,
  output reg [15:0] ramp_left_r
);

  wire [15:0] target_w = {{(16-VOL_W){1'b0}}, vol_code} << `AVF_GAIN_SHIFT;
  reg [15:0] goal_r;
  reg [15:0] goal_nxt;
  wire [15:0] step_w = `AVF_STEP_FULL >> step_sel;
  wire [17:0] per_code_w = ((`AVF_PERIOD_NUM << step_sel) + `AVF_PERIOD_RND) >> `AVF_PERIOD_SHIFT;
  wire [VOL_W-1:0] cur_code_w = goal_r[`AVF_GAIN_SHIFT+VOL_W-1:`AVF_GAIN_SHIFT];
  wire [VOL_W-1:0] diff_w = (vol_code > cur_code_w) ? vol_code - cur_code_w : cur_code_w - vol_code;
  wire [25:0] dur_w = diff_w * per_code_w[7:0];

  always @* begin
    goal_nxt = goal_r;
    if (vol_wr) begin
      goal_nxt = target_w;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      goal_r <= 16'h0000;
      gain_r <= 16'h0000;
      ramp_busy_r <= 1'b0;
      ramp_left_r <= 16'h0000;
    end else if (clear) begin
      goal_r <= 16'h0000;
      gain_r <= 16'h0000;
      ramp_busy_r <= 1'b0;
      ramp_left_r <= 16'h0000;
    end else begin
      goal_r <= goal_nxt;
      if (vol_wr && !fade_en) begin
        gain_r <= target_w;
        ramp_busy_r <= 1'b0;
        ramp_left_r <= 16'h0000;
      end else if (vol_wr) begin
        ramp_left_r <= dur_w[15:0];
        ramp_busy_r <= (diff_w != {VOL_W{1'b0}});
      end else if (group_tick && ramp_busy_r) begin
        if (gain_r + step_w < goal_r) begin
          gain_r <= gain_r + step_w;
        end else if (gain_r > goal_r + step_w) begin
          gain_r <= gain_r - step_w;
        end else begin
          gain_r <= goal_r;
        end
        ramp_left_r <= ramp_left_r - 16'h0001;
        if (ramp_left_r <= 16'h0001) begin
          ramp_busy_r <= 1'b0;
          gain_r <= goal_r;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* File: verif/avf_host_model.sv */
// host model: sends an opcode byte then one data byte per command
// assumes bytes are driven at the falling clock edge
`timescale 1ns/1ns
`default_nettype none
module avf_host_model (
  // clock
  input wire logic clk,
  // command bytes
  output logic [7:0] cmd_byte,
  output logic cmd_valid,
  output logic cmd_first,
  output logic cmd_from_i2c
);
  initial begin
    cmd_byte = 8'h00;
    cmd_valid = 1'b0;
    cmd_first = 1'b0;
    cmd_from_i2c = 1'b0;
  end
  // whole command, then bus changed once released
  task automatic send(input logic [7:0] op, input logic [7:0] dat, input logic i2c);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_first = 1'b1;
    cmd_byte = op;
    @(negedge clk);
    cmd_first = 1'b0;
    cmd_from_i2c = i2c;
    cmd_byte = dat;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_from_i2c = ~i2c;
    cmd_byte = ~dat;
  endtask
endmodule
`default_nettype wire

/* File: verif/avf_props.sv */
// checker for the command block, watches top-level ports only
// assumes one clock and async active-high reset
`timescale 1ns/1ns
`default_nettype none
module avf_props #(
  parameter CHANNELS = 4,
  parameter VOL_W = 7
) (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // inputs
  input wire cmd_valid,
  input wire cmd_first,
  input wire cmd_from_i2c,
  input wire chip_powered,
  input wire chip_transition,
  input wire playing,
  input wire power_down_evt,
  input wire [7:0] stored_protect_code,
  input wire [CHANNELS-1:0] chan_vol_wr,
  input wire [CHANNELS*VOL_W-1:0] chan_vol_code,
  // outputs
  input wire analog_enable_hi_r,
  input wire analog_busy_r,
  input wire analog_up_r,
  input wire speaker_neg_out_oe_r,
  input wire speaker_pos_out_gnd_r,
  input wire mid_reference_out_gnd_r,
  input wire line_out_pin_gnd_r,
  input wire [3:0] amp_volume_code_r,
  input wire fade_en_r,
  input wire [CHANNELS*16-1:0] chan_gain,
  input wire flash_access_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_power_down_cmd_clears: assert property (power_down_evt |=> amp_volume_code_r == 4'h8 && !fade_en_r)
    else $error("power-down did not restore volume and fade");
  a_lock_code: assert property (!flash_access_r && stored_protect_code == 8'h69 |=> !flash_access_r)
    else $error("flash mode entered with locked code");
  a_flash_sticky: assert property (flash_access_r |=> flash_access_r)
    else $error("flash mode left without reset");
  a_i2c_ignored: assert property (cmd_valid && !cmd_first && cmd_from_i2c && !flash_access_r |=> !flash_access_r)
    else $error("flash mode entered over i2c");
  a_vol_cause: assert property (!$stable(amp_volume_code_r) |-> $past(cmd_valid) || $past(power_down_evt))
    else $error("volume changed without command");
  a_off_pins: assert property (!analog_up_r && !analog_busy_r |-> !speaker_neg_out_oe_r && speaker_pos_out_gnd_r
    && mid_reference_out_gnd_r && line_out_pin_gnd_r)
    else $error("pins not parked while analog off");
  a_setup_refused: assert property (cmd_valid && !cmd_first && !power_down_evt && (playing || !chip_powered
    || chip_transition) |=> $stable(analog_enable_hi_r))
    else $error("setup applied while refused");
  a_no_fade_step: assert property (chan_vol_wr[0] && !fade_en_r && !power_down_evt
    |=> chan_gain[15:0] == 16'({$past(chan_vol_code[VOL_W-1:0]), 8'h00}))
    else $error("gain not applied at once with fade off");
  a_busy_bounded: assert property ($rose(analog_busy_r) |-> ##[1:200] !analog_busy_r)
    else $error("analog transition did not end");
endmodule
bind avf_top avf_props #(.CHANNELS(CHANNELS), .VOL_W(VOL_W)) u_props (.clk(clk), .sys_rst(sys_rst),
  .cmd_valid(cmd_valid), .cmd_first(cmd_first), .cmd_from_i2c(cmd_from_i2c), .chip_powered(chip_powered),
  .chip_transition(chip_transition), .playing(playing), .power_down_evt(power_down_evt),
  .stored_protect_code(stored_protect_code), .chan_vol_wr(chan_vol_wr), .chan_vol_code(chan_vol_code),
  .analog_enable_hi_r(analog_enable_hi_r), .analog_busy_r(analog_busy_r), .analog_up_r(analog_up_r),
  .speaker_neg_out_oe_r(speaker_neg_out_oe_r), .speaker_pos_out_gnd_r(speaker_pos_out_gnd_r),
  .mid_reference_out_gnd_r(mid_reference_out_gnd_r), .line_out_pin_gnd_r(line_out_pin_gnd_r),
  .amp_volume_code_r(amp_volume_code_r), .fade_en_r(fade_en_r), .chan_gain(chan_gain),
  .flash_access_r(flash_access_r));
`default_nettype wire

/* File: verif/tb_top.sv */
// testbench for the command block: setup, volume, fade and flash entry
// assumes transition times shortened to 80 ns suppressed, 40 ns plain
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 1'b0, sys_rst = 1'b1, chip_powered = 1'b0, chip_transition = 1'b0, playing = 1'b0;
  logic power_down_evt = 1'b0, group_tick = 1'b0;
  logic [7:0] stored_protect_code = 8'h69, cmd_byte;
  logic [3:0] chan_vol_wr = 4'h0;
  logic [27:0] chan_vol_code = 28'h0;
  logic cmd_valid, cmd_first, cmd_from_i2c, analog_enable_hi_r, analog_enable_lo_r, pop_suppress_r;
  logic analog_up_r, analog_busy_r, line_at_mid_r, speaker_neg_out_oe_r, speaker_pos_out_gnd_r;
  logic mid_reference_out_gnd_r, line_out_pin_gnd_r, fade_en_r, flash_access_r;
  logic [3:0] amp_volume_code_r, chan_ramp_busy;
  logic [2:0] ramp_step_sel_r;
  logic [1:0] dac_gain_r, ain_gain_r;
  logic amp_class_sel_r, hpf_en_r, stop_fade_r;
  logic [63:0] chan_gain;
  int num_errors = 0, checks_done = 0;
  always #2 clk = ~clk;
  avf_host_model host (.clk(clk), .cmd_byte(cmd_byte), .cmd_valid(cmd_valid), .cmd_first(cmd_first),
    .cmd_from_i2c(cmd_from_i2c));
  avf_top #(.SUP_RISE_NS(80), .SUP_FALL_NS(80), .PLAIN_RISE_NS(40), .PLAIN_FALL_NS(40)) dut (
    .clk(clk), .sys_rst(sys_rst), .cmd_byte(cmd_byte), .cmd_valid(cmd_valid), .cmd_first(cmd_first),
    .cmd_from_i2c(cmd_from_i2c), .chip_powered(chip_powered), .chip_transition(chip_transition),
    .playing(playing), .power_down_evt(power_down_evt), .stored_protect_code(stored_protect_code),
    .group_tick(group_tick), .chan_vol_wr(chan_vol_wr), .chan_vol_code(chan_vol_code),
    .amp_class_sel_r(amp_class_sel_r), .hpf_en_r(hpf_en_r), .stop_fade_r(stop_fade_r),
    .dac_gain_r(dac_gain_r), .ain_gain_r(ain_gain_r),
    .analog_enable_hi_r(analog_enable_hi_r), .analog_enable_lo_r(analog_enable_lo_r),
    .pop_suppress_r(pop_suppress_r), .analog_up_r(analog_up_r), .analog_busy_r(analog_busy_r),
    .line_at_mid_r(line_at_mid_r), .speaker_neg_out_oe_r(speaker_neg_out_oe_r),
    .speaker_pos_out_gnd_r(speaker_pos_out_gnd_r), .mid_reference_out_gnd_r(mid_reference_out_gnd_r),
    .line_out_pin_gnd_r(line_out_pin_gnd_r), .amp_volume_code_r(amp_volume_code_r), .fade_en_r(fade_en_r),
    .ramp_step_sel_r(ramp_step_sel_r), .chan_gain(chan_gain), .chan_ramp_busy(chan_ramp_busy),
    .flash_access_r(flash_access_r));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic pulse_pd;
    @(negedge clk);
    power_down_evt = 1'b1;
    @(negedge clk);
    power_down_evt = 1'b0;
  endtask
  task automatic tick;
    group_tick = 1'b1;
    @(negedge clk);
    group_tick = 1'b0;
    @(negedge clk);
  endtask
  task automatic t_setup;
    logic [7:0] b [4] = '{8'h03, 8'h04, 8'h05, 8'h07};
    int n;
    host.send(8'h04, 8'h07, 1'b0);
    chk(analog_busy_r, 1'b0, "setup while off");
    chip_powered = 1'b1;
    for (int i = 0; i < 4; i++) begin
      host.send(8'h05, 8'hA8 | b[i], 1'b0);
      chk({analog_busy_r, analog_enable_hi_r, analog_enable_lo_r, pop_suppress_r}, {1'b1, b[i][2:0]}, "up");
      chk({amp_class_sel_r, hpf_en_r, stop_fade_r, dac_gain_r, ain_gain_r}, 16'h35, "setup fields");
      n = 0;
      while (analog_busy_r === 1'b1 && n < 500) begin
        @(negedge clk);
        n++;
      end
      chk((n > 15 && n < 25) == (b[i][2] && b[i][0]), 1'b1, "rise time");
      chk({analog_up_r, line_at_mid_r}, {1'b1, b[i][2]}, "settled");
      playing = 1'b1;
      host.send(8'h04, 8'h00, 1'b0);
      chk({analog_busy_r, analog_up_r}, 2'b01, "setup while playing");
      playing = 1'b0;
      host.send(8'h04, {7'h00, b[i][0]}, 1'b0);
      n = 0;
      while (analog_busy_r === 1'b1 && n < 500) begin
        @(negedge clk);
        n++;
      end
      chk((n > 15 && n < 25) == (b[i][2] && b[i][0]), 1'b1, "fall time");
      chk({analog_up_r, speaker_neg_out_oe_r, speaker_pos_out_gnd_r, mid_reference_out_gnd_r,
        line_out_pin_gnd_r}, 5'h07, "pins off");
    end
    $display("test setup done");
  endtask
  task automatic t_volume;
    playing = 1'b1;
    for (int c = 0; c < 16; c++) begin
      host.send(8'h08, {2'b00, c[3:0], 2'b00}, 1'b0);
      chk(amp_volume_code_r, (c == 1 || c == 2) ? 16'h0 : 16'(c), "volume");
    end
    host.send(8'h08, 8'hE9, 1'b0);
    chk(amp_volume_code_r, 16'hF, "reserved bits");
    playing = 1'b0;
    host.send(8'h05, 8'hAF, 1'b0);
    pulse_pd();
    @(negedge clk);
    chk(amp_volume_code_r, 16'h8, "after power-down");
    chk({amp_class_sel_r, hpf_en_r, stop_fade_r, dac_gain_r, ain_gain_r, analog_enable_hi_r,
      analog_enable_lo_r, pop_suppress_r, analog_busy_r, line_out_pin_gnd_r}, 16'h001, "setup cleared");
    $display("test volume done");
  endtask
  task automatic t_fade;
    int n;
    host.send(8'h0C, 8'h0F, 1'b0);
    chk({fade_en_r, ramp_step_sel_r}, 4'hF, "fade set");
    host.send(8'h0C, 8'h1F, 1'b0);
    chk({fade_en_r, ramp_step_sel_r}, 4'hF, "fade reserved");
    host.send(8'h0C, 8'h01, 1'b0);
    chan_vol_code[6:0] = 7'h03;
    chan_vol_wr[0] = 1'b1;
    @(negedge clk);
    chan_vol_wr[0] = 1'b0;
    @(negedge clk);
    tick();
    chk(chan_gain[15:0], 16'h0080, "first step");
    n = 1;
    while (chan_ramp_busy[0] === 1'b1 && n < 50) begin
      tick();
      n++;
    end
    chk(n, 16'd6, "ramp ticks");
    chk(chan_gain[15:0], 16'h0300, "ramp end");
    host.send(8'h0C, 8'h0F, 1'b0);
    chan_vol_code[6:0] = 7'h02;
    chan_vol_wr[0] = 1'b1;
    @(negedge clk);
    chan_vol_wr[0] = 1'b0;
    tick();
    chk(chan_gain[15:0], 16'h02FF, "fine step");
    n = 1;
    while (chan_ramp_busy[0] === 1'b1 && n < 200) begin
      tick();
      n++;
    end
    chk(n, 16'd132, "fine ramp ticks");
    chk(chan_gain[15:0], 16'h0200, "fine ramp end");
    host.send(8'h0C, 8'h00, 1'b0);
    chan_vol_code[6:0] = 7'h05;
    chan_vol_wr[0] = 1'b1;
    @(negedge clk);
    chan_vol_wr[0] = 1'b0;
    chk(chan_gain[15:0], 16'h0500, "no fade");
    $display("test fade done");
  endtask
  task automatic t_flash;
    host.send(8'h10, 8'h69, 1'b0);
    chk(flash_access_r, 1'b0, "locked code");
    stored_protect_code = 8'h5A;
    host.send(8'h10, 8'h5A, 1'b1);
    chk(flash_access_r, 1'b0, "over i2c");
    host.send(8'h10, 8'h5B, 1'b0);
    chk(flash_access_r, 1'b0, "wrong code");
    host.send(8'h10, 8'h5A, 1'b0);
    chk(flash_access_r, 1'b1, "match");
    pulse_pd();
    host.send(8'h0C, 8'h01, 1'b0);
    chk(flash_access_r, 1'b1, "stays");
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    chk({flash_access_r, fade_en_r, amp_volume_code_r}, 6'h08, "after reset");
    $display("test flash done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    end_of_test();
  end
  initial begin
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    chk({amp_volume_code_r, fade_en_r, flash_access_r, line_out_pin_gnd_r}, 16'h41, "reset");
    t_setup();
    t_volume();
    t_fade();
    t_flash();
    end_of_test();
  end
endmodule
`default_nettype wire
